// >>> include/ebt_consts.vh
// Purpose: Shared timing and state constants of the external bus sequencer.
// Assumes: The sequencer clock is the oscillator clock, one period per Tcp.
// Notes:   Times are counted in Tcp; cycle counts are derived from them.
`ifndef EBT_CONSTS_VH
`define EBT_CONSTS_VH

// ********************************************************************
// Clock and reference period
// ********************************************************************
`define EBT_CLK_NS        40
`define EBT_TCP_NS        40
`define EBT_DELTA_NS      20

// ********************************************************************
// Strobe and phase lengths in Tcp
// ********************************************************************
`define EBT_ALE_TCP       2
`define EBT_HOLD_TCP      1
`define EBT_GAP_TCP       2
`define EBT_STORE_TCP     3
`define EBT_RDWR_TCP      6
`define EBT_FLOAT_F_TCP   1
`define EBT_FLOAT_R_TCP   2
`define EBT_WHOLD_TCP     1

// ********************************************************************
// Derived cycle counts
// ********************************************************************
`define EBT_CYC(t)        (((t) * `EBT_TCP_NS + `EBT_CLK_NS - 1) / `EBT_CLK_NS)

// ********************************************************************
// Request kinds and machine cycle phases
// ********************************************************************
`define EBT_KIND_FETCH    2'h0
`define EBT_KIND_READ     2'h1
`define EBT_KIND_WRITE    2'h2
`define EBT_PHASES        12
`define EBT_PH_SAMPLE     4'h9
`define EBT_PH_UPDATE     4'hb

`endif

// >>> core/ebt_port_sampler.v
// Purpose: Samples port pins and updates port output latches.
// Assumes: Strobes are one-cycle pulses from the machine phase counter.
// Notes:   All outputs are registered.
`timescale 1ns/100ps
`default_nettype none
module ebt_port_sampler #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             mclk_i,
  input  wire             rst_i,
  // Phase strobes
  input  wire             sample_i,
  input  wire             update_i,
  // Port data
  input  wire [WIDTH-1:0] pin_i,
  input  wire [WIDTH-1:0] wdata_i,
  output reg  [WIDTH-1:0] sampled_o,
  output reg  [WIDTH-1:0] out_o
);

  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sampled_o <= {WIDTH{1'b0}};
      out_o     <= {WIDTH{1'b1}};
    end
    else
    begin
      if (sample_i)
      begin
        sampled_o <= pin_i;
      end
      if (update_i)
      begin
        out_o <= wdata_i;
      end
    end
  end

endmodule // ebt_port_sampler
`default_nettype wire

// >>> core/ebt_bus_seq.v
// Purpose: Sequences fetch, data read and data write cycles on the
//          external bus, and times port sampling and port updates.
// Assumes: One request at a time; the partner meets its own timing.
// Notes:   Strobe outputs are active low where the name says so.
`timescale 1ns/100ps
`default_nettype none
`include "ebt_consts.vh"
module ebt_bus_seq #(
  parameter PORT_W = 8
) (
  // Clock and reset
  input  wire              mclk_i,
  input  wire              rst_i,
  // Request side
  input  wire              req_i,
  input  wire [1:0]        req_kind_i,
  input  wire [15:0]       req_addr_i,
  input  wire [7:0]        req_wdata_i,
  output reg               busy_o,
  output reg               done_o,
  output reg  [7:0]        rdata_o,
  // External bus
  output reg               ale_o,
  output reg               program_store_strobe_n_o,
  output reg               rd_n_o,
  output reg               wr_n_o,
  input  wire [7:0]        low_addr_data_port_i,
  output reg  [7:0]        low_addr_data_port_o,
  output reg               low_addr_data_port_oe_o,
  output reg  [7:0]        high_addr_port_o,
  // General port
  input  wire [PORT_W-1:0] port_pin_i,
  input  wire [PORT_W-1:0] port_wdata_i,
  output wire [PORT_W-1:0] port_sampled_o,
  output wire [PORT_W-1:0] port_o,
  output reg               state_five_phase_two_o,
  output reg               state_six_phase_two_o
);

  // ******************************************************************
  // States and loads
  // ******************************************************************
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_ALE  = 6'h02;
  localparam [5:0] ST_HOLD = 6'h04;
  localparam [5:0] ST_GAP  = 6'h08;
  localparam [5:0] ST_STRB = 6'h10;
  localparam [5:0] ST_POST = 6'h20;

  localparam integer LD_ALE   = `EBT_CYC(`EBT_ALE_TCP) - 1;
  localparam integer LD_HOLD  = `EBT_CYC(`EBT_HOLD_TCP) - 1;
  localparam integer LD_GAP   = `EBT_CYC(`EBT_GAP_TCP) - 1;
  localparam integer LD_STORE = `EBT_CYC(`EBT_STORE_TCP) - 1;
  localparam integer LD_RDWR  = `EBT_CYC(`EBT_RDWR_TCP) - 1;
  localparam integer LD_FLT_F = `EBT_CYC(`EBT_FLOAT_F_TCP) - 1;
  localparam integer LD_FLT_R = `EBT_CYC(`EBT_FLOAT_R_TCP) - 1;
  localparam integer LD_WHOLD = `EBT_CYC(`EBT_WHOLD_TCP) - 1;
  localparam integer PH_LAST  = `EBT_PHASES - 1;

  reg  [5:0]  state_q;
  reg  [5:0]  state_d;
  reg  [2:0]  cnt_q;
  reg  [2:0]  cnt_d;
  reg  [1:0]  kind_q;
  reg  [1:0]  kind_d;
  reg  [15:0] addr_q;
  reg  [15:0] addr_d;
  reg  [7:0]  wdat_q;
  reg  [7:0]  wdat_d;
  reg         done_d;
  reg         cap_d;
  reg  [3:0]  phase_q;
  wire        cnt_end;
  wire        is_fetch;
  wire        is_write;

  assign cnt_end  = (cnt_q == 3'h0);
  assign is_fetch = (kind_q == `EBT_KIND_FETCH);
  assign is_write = (kind_q == `EBT_KIND_WRITE);

  // ******************************************************************
  // Cycle sequencer
  // ******************************************************************
  always @*
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    kind_d  = kind_q;
    addr_d  = addr_q;
    wdat_d  = wdat_q;
    done_d  = 1'b0;
    cap_d   = 1'b0;
    if (!cnt_end)
    begin
      cnt_d = cnt_q - 3'h1;
    end
    case (state_q)
      ST_IDLE:
      begin
        if (req_i)
        begin
          state_d = ST_ALE;
          cnt_d   = LD_ALE[2:0];
          kind_d  = req_kind_i;
          addr_d  = req_addr_i;
          wdat_d  = req_wdata_i;
        end
      end
      ST_ALE:
      begin
        if (cnt_end)
        begin
          state_d = ST_HOLD;
          cnt_d   = LD_HOLD[2:0];
        end
      end
      ST_HOLD:
      begin
        if (cnt_end)
        begin
          if (is_fetch)
          begin
            state_d = ST_STRB;
            cnt_d   = LD_STORE[2:0];
          end
          else
          begin
            state_d = ST_GAP;
            cnt_d   = LD_GAP[2:0];
          end
        end
      end
      ST_GAP:
      begin
        if (cnt_end)
        begin
          state_d = ST_STRB;
          cnt_d   = LD_RDWR[2:0];
        end
      end
      ST_STRB:
      begin
        if (cnt_end)
        begin
          state_d = ST_POST;
          cap_d   = !is_write;
          if (is_fetch)
          begin
            cnt_d = LD_FLT_F[2:0];
          end
          else if (is_write)
          begin
            cnt_d = LD_WHOLD[2:0];
          end
          else
          begin
            cnt_d = LD_FLT_R[2:0];
          end
        end
      end
      ST_POST:
      begin
        if (cnt_end)
        begin
          state_d = ST_IDLE;
          done_d  = 1'b1;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
        cnt_d   = 3'h0;
      end
    endcase
  end

  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_IDLE;
      cnt_q   <= 3'h0;
      kind_q  <= 2'h0;
      addr_q  <= 16'h0000;
      wdat_q  <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      kind_q  <= kind_d;
      addr_q  <= addr_d;
      wdat_q  <= wdat_d;
    end
  end

  // ******************************************************************
  // Registered bus outputs
  // ******************************************************************
  // Outputs follow the next state so every pin comes from a flop.
  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ale_o                    <= 1'b0;
      program_store_strobe_n_o <= 1'b1;
      rd_n_o                   <= 1'b1;
      wr_n_o                   <= 1'b1;
      low_addr_data_port_o     <= 8'h00;
      low_addr_data_port_oe_o  <= 1'b0;
      high_addr_port_o         <= 8'h00;
      busy_o                   <= 1'b0;
      done_o                   <= 1'b0;
      rdata_o                  <= 8'h00;
    end
    else
    begin
      ale_o                    <= (state_d == ST_ALE);
      program_store_strobe_n_o <= !((state_d == ST_STRB) &&
                                    (kind_d == `EBT_KIND_FETCH));
      rd_n_o                   <= !((state_d == ST_STRB) &&
                                    (kind_d == `EBT_KIND_READ));
      wr_n_o                   <= !((state_d == ST_STRB) &&
                                    (kind_d == `EBT_KIND_WRITE));
      high_addr_port_o         <= addr_d[15:8];
      busy_o                   <= (state_d != ST_IDLE);
      done_o                   <= done_d;
      if ((state_d == ST_ALE) || (state_d == ST_HOLD))
      begin
        low_addr_data_port_o    <= addr_d[7:0];
        low_addr_data_port_oe_o <= 1'b1;
      end
      else if ((kind_d == `EBT_KIND_WRITE) && (state_d != ST_IDLE))
      begin
        low_addr_data_port_o    <= wdat_d;
        low_addr_data_port_oe_o <= 1'b1;
      end
      else
      begin
        low_addr_data_port_oe_o <= 1'b0;
      end
      if (cap_d)
      begin
        rdata_o <= low_addr_data_port_i;
      end
    end
  end

  // ******************************************************************
  // Machine phase counter and port timing
  // ******************************************************************
  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      phase_q                <= 4'h0;
      state_five_phase_two_o <= 1'b0;
      state_six_phase_two_o  <= 1'b0;
    end
    else
    begin
      phase_q                <= (phase_q == PH_LAST[3:0]) ? 4'h0 :
                                phase_q + 4'h1;
      state_five_phase_two_o <= (phase_q == `EBT_PH_SAMPLE);
      state_six_phase_two_o  <= (phase_q == `EBT_PH_UPDATE);
    end
  end

  ebt_port_sampler #(
    .WIDTH     (PORT_W)
  ) u_port (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .sample_i  (phase_q == `EBT_PH_SAMPLE),
    .update_i  (phase_q == `EBT_PH_UPDATE),
    .pin_i     (port_pin_i),
    .wdata_i   (port_wdata_i),
    .sampled_o (port_sampled_o),
    .out_o     (port_o)
  );

endmodule // ebt_bus_seq
`default_nettype wire

// >>> tb/ebt_checker.sv
// Purpose: Port timing assertions of the external bus sequencer.
// Assumes: One clock domain, asynchronous active-high reset.
// Notes:   Attached by bind; sees only the sequencer ports.
`timescale 1ns/100ps
`default_nettype none
module ebt_checker #(
  parameter PORT_W = 8
) (
  // Observed ports
  input wire logic              mclk_i,
  input wire logic              rst_i,
  input wire logic              ale_o,
  input wire logic              program_store_strobe_n_o,
  input wire logic              rd_n_o,
  input wire logic              wr_n_o,
  input wire logic              done_o,
  input wire logic [7:0]        rdata_o,
  input wire logic [7:0]        low_addr_data_port_i,
  input wire logic [7:0]        low_addr_data_port_o,
  input wire logic              low_addr_data_port_oe_o,
  input wire logic [PORT_W-1:0] port_pin_i,
  input wire logic [PORT_W-1:0] port_wdata_i,
  input wire logic [PORT_W-1:0] port_sampled_o,
  input wire logic [PORT_W-1:0] port_o,
  input wire logic              state_five_phase_two_o,
  input wire logic              state_six_phase_two_o
);
  wire       ps = program_store_strobe_n_o;
  wire       oe = low_addr_data_port_oe_o;
  wire [7:0] ad = low_addr_data_port_o;
  wire [7:0] di = low_addr_data_port_i;
  wire       s6 = state_six_phase_two_o;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_ale; $rose(ale_o) |=> ale_o ##1 !ale_o; endproperty
  a_ale: assert property (p_ale) else $error("latch width");
  property p_adr; $fell(ale_o) |-> $past(oe) && oe && $stable(ad); endproperty
  a_adr: assert property (p_adr) else $error("address timing");
  property p_ps; $fell(ps) |-> (!ps && !oe)[*3] ##1 ps; endproperty
  a_ps: assert property (p_ps) else $error("store strobe");
  property p_pcap; $rose(ps) |-> rdata_o == $past(di) ##1 done_o; endproperty
  a_pcap: assert property (p_pcap) else $error("fetch capture");
  property p_rd;
    $fell(rd_n_o) |-> $past(ale_o, 4) && !$past(ale_o, 3)
      ##0 !rd_n_o[*6] ##1 rd_n_o;
  endproperty
  a_rd: assert property (p_rd) else $error("read strobe");
  property p_rcap; $rose(rd_n_o) |-> rdata_o == $past(di) ##0 !oe[*2]
    ##1 done_o; endproperty
  a_rcap: assert property (p_rcap) else $error("read capture");
  property p_wr; $fell(wr_n_o) |-> $past(oe) && $stable(ad)
    ##0 (!wr_n_o && oe)[*6] ##1 wr_n_o; endproperty
  a_wr: assert property (p_wr) else $error("write strobe");
  property p_wh; $rose(wr_n_o) |-> oe && $stable(ad); endproperty
  a_wh: assert property (p_wh) else $error("write hold");
  property p_ph; state_five_phase_two_o |->
    port_sampled_o == $past(port_pin_i) ##2 s6; endproperty
  a_ph: assert property (p_ph) else $error("port sample");
  property p_po; s6 |-> port_o == $past(port_wdata_i); endproperty
  a_po: assert property (p_po) else $error("port update");
endmodule // ebt_checker
bind ebt_bus_seq ebt_checker #(.PORT_W(PORT_W)) i_chk (.mclk_i, .rst_i,
  .ale_o, .program_store_strobe_n_o, .rd_n_o, .wr_n_o, .done_o, .rdata_o,
  .low_addr_data_port_i, .low_addr_data_port_o, .low_addr_data_port_oe_o,
  .port_pin_i, .port_wdata_i, .port_sampled_o, .port_o,
  .state_five_phase_two_o, .state_six_phase_two_o);
`default_nettype wire

// >>> tb/ebt_mem_model.sv
// Purpose: External program and data memory with its address latch.
// Assumes: One shared byte array, indexed by the latched low address.
// Notes:   Slow mode answers in the last strobe cycle of a fetch and in the last two of a read.
`timescale 1ns/100ps
`default_nettype none
module ebt_mem_model (
  // Bus pins
  input  wire logic       mclk_i,
  input  wire logic       slow_i,
  input  wire logic       ale_i,
  input  wire logic       ps_n_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  input  wire logic [7:0] bus_i,
  output var  logic [7:0] bus_o
);
  logic [7:0] mem [0:255];
  logic [7:0] adr_q;
  logic [7:0] last_q = 8'h00;
  logic [2:0] cnt_q;
  wire        rdg = !ps_n_i || !rd_n_i;
  wire [2:0]  lim = !slow_i ? 3'h0 : !ps_n_i ? 3'h2 : 3'h4;
  initial for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5a;
  always @(posedge mclk_i)
  begin
    if (ale_i) adr_q <= bus_i;
    if (!wr_n_i) mem[adr_q] <= bus_i;
    cnt_q <= rdg ? cnt_q + 3'h1 : 3'h0;
    if (rdg) last_q <= mem[adr_q];
  end
  // A released bus shows the inverse of the last byte read from the array in a strobe cycle.
  always_comb bus_o = (rdg && cnt_q >= lim) ? mem[adr_q] : ~last_q;
endmodule // ebt_mem_model
`default_nettype wire

// >>> tb/test_external_bus_cycle_timing.sv
// Purpose: Self-checking bench of the external bus sequencer.
// Assumes: Memory model answers on the shared low port.
// Notes:   Expected bytes follow the model fill pattern or a byte written before.
`timescale 1ns/100ps
`default_nettype none
module test_external_bus_cycle_timing;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        req_i = 1'b0;
  logic        slow = 1'b0;
  logic [1:0]  kind = 2'h0;
  logic [15:0] adr = 16'h0000;
  logic [7:0]  wd = 8'h00;
  logic [7:0]  pin = 8'h00;
  logic [7:0]  pwd = 8'h00;
  logic        busy, done, ale, psn, rdn, wrn, oe, s5, s6;
  logic [7:0]  rdata, ado, hi, mo, psam, pout;
  wire  [7:0]  bus = oe ? ado : mo;
  int          n_fail = 0;
  int          num_checks = 0;
  int          cyc = 0;
  ebt_bus_seq i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req_i),
    .req_kind_i(kind), .req_addr_i(adr), .req_wdata_i(wd), .busy_o(busy),
    .done_o(done), .rdata_o(rdata), .ale_o(ale),
    .program_store_strobe_n_o(psn), .rd_n_o(rdn), .wr_n_o(wrn),
    .low_addr_data_port_i(bus), .low_addr_data_port_o(ado),
    .low_addr_data_port_oe_o(oe), .high_addr_port_o(hi),
    .port_pin_i(pin), .port_wdata_i(pwd), .port_sampled_o(psam),
    .port_o(pout), .state_five_phase_two_o(s5), .state_six_phase_two_o(s6));
  ebt_mem_model i_mem (.mclk_i(mclk_i), .slow_i(slow), .ale_i(ale),
    .ps_n_i(psn), .rd_n_i(rdn), .wr_n_i(wrn), .bus_i(bus), .bus_o(mo));
  initial
  begin
    forever #20 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Runs one bus cycle; a refused request is raised mid-cycle on demand.
  task automatic op(input logic [1:0] k, input logic [15:0] a,
                    input logic [7:0] x, input int ncyc, input logic rf);
    int n;
    @(posedge mclk_i);
    req_i <= 1'b1;
    kind <= k;
    adr <= a;
    wd <= x;
    @(posedge mclk_i);
    req_i <= 1'b0;
    n = 1;
    while (done !== 1'b1 && n < 40)
    begin
      @(posedge mclk_i);
      req_i <= rf && n == 2;
      kind <= 2'h2;
      #1 n++;
      if (n == 4) chk(hi, a[15:8]);
    end
    chk(n, ncyc);
    if (k != 2'h2) chk(rdata, x);
    repeat (2) @(posedge mclk_i);
    #1 chk(busy, 1'b0);
  endtask
  task automatic t_fetch;
    op(2'h0, 16'h12a5, 8'hff, 8, 1'b0);
    slow <= 1'b1;
    op(2'h0, 16'h34c3, 8'h99, 8, 1'b1);
    slow <= 1'b0;
  endtask
  task automatic t_wr_rd;
    op(2'h2, 16'h5577, 8'hc3, 13, 1'b0);
    slow <= 1'b1;
    op(2'h1, 16'h5577, 8'hc3, 14, 1'b0);
    slow <= 1'b0;
    op(2'h1, 16'h0010, 8'h4a, 14, 1'b0);
  endtask
  task automatic t_port;
    int n;
    @(posedge mclk_i);
    pin <= 8'h96;
    pwd <= 8'h69;
    n = 0;
    while (s5 !== 1'b1 && n < 30)
    begin
      @(posedge mclk_i);
      #1 n++;
    end
    chk(psam, 8'h96);
    repeat (2) @(posedge mclk_i);
    #1 chk(s6, 1'b1);
    chk(pout, 8'h69);
  endtask
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      finish_test();
    end
  end
  initial
  begin
    repeat (2) @(posedge mclk_i);
    #1 chk({ale, psn, rdn, wrn, oe, busy, done}, 16'h0038);
    chk(pout, 8'hff);
    @(posedge mclk_i);
    rst_i <= 1'b0;
    t_fetch();
    t_wr_rd();
    t_port();
    finish_test();
  end
endmodule // test_external_bus_cycle_timing
`default_nettype wire
